// File: rtl/uhpd_pkg.sv
// Purpose: Shared constants and types for the host port disable sequencer
// Assumes: 50 MHz controller clock
// Notes:   Command and state codes are local encodings
package uhpd_pkg;
    // Clock and timer base
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
    // Least power-down wait; must be exceeded, hence one extra tick
    localparam int PD_WAIT_MS    = 4;
    localparam int PD_WAIT_TICKS = PD_WAIT_MS * 1000000 / TICK_NS + 1;
    localparam int TMR_W         = 16;

    // Bus map, byte addresses
    localparam int         ADDR_W    = 5;
    localparam int         DATA_W    = 32;
    localparam logic [4:0] REG_CTRL  = 5'h00;
    localparam logic [4:0] REG_XCVR  = 5'h04;
    localparam logic [4:0] REG_STAT  = 5'h08;
    localparam logic [4:0] REG_CLR   = 5'h0C;
    localparam logic [4:0] REG_IEN   = 5'h10;

    // Field positions
    localparam int CMD_W         = 3;
    localparam int CTRL_CMD_LSB  = 0;
    localparam int CTRL_BUSY_BIT = 8;
    localparam int CTRL_DISC_BIT = 9;
    localparam int XCVR_OPM_LSB  = 0;
    localparam int XCVR_XSEL_LSB = 2;
    localparam int XCVR_TERM_BIT = 4;
    localparam int XCVR_SPD_LSB  = 5;
    localparam int XCVR_LINE_LSB = 8;
    localparam int STAT_W        = 2;
    localparam int STAT_DONE_BIT = 0;
    localparam int STAT_RST_BIT  = 1;

    // Host transition commands
    localparam logic [2:0] CMD_GO_WAIT_CONNECT = 3'h1;
    localparam logic [2:0] CMD_GO_DISABLED     = 3'h2;
    localparam logic [2:0] CMD_GO_RESET        = 3'h3;
    localparam logic [2:0] CMD_GO_OPERATIONAL  = 3'h4;

    // Host state monitor codes
    localparam logic [2:0] HST_IDLE         = 3'h0;
    localparam logic [2:0] HST_WAIT_CONNECT = 3'h1;
    localparam logic [2:0] HST_DISABLED     = 3'h2;
    localparam logic [2:0] HST_RESET        = 3'h3;
    localparam logic [2:0] HST_OPERATIONAL  = 3'h4;

    // Transceiver settings
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_PWRDN  = 2'h2;
    localparam logic [1:0] SEL_HS     = 2'h0;
    localparam logic [1:0] SEL_FS     = 2'h1;
    localparam logic [1:0] SEL_LS     = 2'h2;
    localparam logic       TERM_HS    = 1'b0;
    localparam logic       TERM_FS    = 1'b1;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_DIS_TXN = 4'h2,
        ST_DIS_PD  = 4'h4,
        ST_RST_TXN = 4'h8
    } uhpd_state_t;
endpackage

// File: rtl/uhpd_tmr_if.sv
// Purpose: Carrier between sequencer and power-down timer
// Assumes: One clock domain
// Notes:   Start is a one-cycle pulse
interface uhpd_tmr_if;
    logic start;
    logic done;
    logic busy;
    modport ctl (output start, input done, input busy);
    modport tmr (input start, output done, output busy);
endinterface

// File: rtl/uhpd_sync.sv
// Purpose: Two-flop synchroniser for pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage feeds only the second
module uhpd_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    generate
        if (W < 1) begin : gBad
            $error("uhpd_sync: W must be at least 1");
        end
        for (genvar i = 0; i < W; i++) begin : gBit
            logic meta_r;
            logic sync_r;
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_r <= 1'b0;
                    sync_r <= 1'b0;
                end else begin
                    meta_r <= d[i];
                    sync_r <= meta_r;
                end
            end
            assign q[i] = sync_r;
        end
    endgenerate
endmodule

// File: rtl/uhpd_timer.sv
// Purpose: Post power-down wait timer on a 1 us enable
// Assumes: Start pulses only while idle
// Notes:   Done fires WAIT_TICKS * TICK_CYC cycles after start
module uhpd_timer
    import uhpd_pkg::*;
#(
    parameter int unsigned WAIT_TICKS = PD_WAIT_TICKS
) (
    input  wire logic clk,
    input  wire logic srst,
    uhpd_tmr_if.tmr   tmr
);
    localparam int DIV_W = $clog2(TICK_CYC);

    logic [DIV_W-1:0] divCnt_r;
    logic [TMR_W-1:0] tickCnt_r;
    logic             run_r;
    wire              tick = run_r && (divCnt_r == DIV_W'(TICK_CYC - 1));
    wire              last = tickCnt_r == TMR_W'(WAIT_TICKS - 1);

    generate
        if (WAIT_TICKS < 1 || WAIT_TICKS >= (1 << TMR_W)) begin : gBad
            $error("uhpd_timer: WAIT_TICKS out of range");
        end
    endgenerate

    // Divider restarts on start so the wait never comes up short
    always_ff @(posedge clk) begin
        if (srst || tmr.start || tick) begin
            divCnt_r <= '0;
        end else if (run_r) begin
            divCnt_r <= divCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            run_r     <= 1'b0;
            tickCnt_r <= '0;
        end else if (tmr.start) begin
            run_r     <= 1'b1;
            tickCnt_r <= '0;
        end else if (tick) begin
            run_r     <= !last;
            tickCnt_r <= tickCnt_r + 1'b1;
        end
    end

    assign tmr.done = tick && last;
    assign tmr.busy = run_r;
endmodule

// File: rtl/uhpd_top.sv
// Purpose: Host port sequencer for disable and reset transitions
// Assumes: Avalon-MM slave, one-cycle wait; same-clock transaction status
// Notes:   Full/low speed disable only; chirp handling lives elsewhere
//
// Local design decisions: the address map and the Avalon-MM register port.
module uhpd_top
    import uhpd_pkg::*;
#(
    parameter int unsigned WAIT_TICKS = PD_WAIT_TICKS
) (
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              txnBusy,
    input  wire logic              connectDetected,
    input  wire logic              erraticChirp,
    input  wire logic              portError,
    input  wire logic [1:0]        busLineLevel,
    output logic      [1:0]        transceiverOperationMode,
    output logic      [1:0]        transceiverSpeedSelect,
    output logic                   terminationSelect,
    output logic      [1:0]        portSpeedSetting,
    output logic                   disconnectDetectEn,
    output logic      [2:0]        hostStateMonitor,
    output logic                   resetStart,
    output logic                   irq
);
    import uhpd_pkg::*;

    uhpd_state_t       state_r;
    uhpd_state_t       state_nxt;
    logic              busAck_r;
    logic [DATA_W-1:0] readData_r;
    logic [2:0]        host_state_monitor_r;
    logic              discEn_r;
    logic [1:0]        transceiver_operation_mode_r;
    logic [1:0]        speedSel_r;
    logic              termSel_r;
    logic [1:0]        port_speed_setting_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] ien_r;
    logic [STAT_W-1:0] statSet;
    logic              irq_r;
    logic              resetStart_r;
    logic [1:0]        lineSync;
    logic [DATA_W-1:0] ctrlView;
    logic [DATA_W-1:0] xcvrView;

    uhpd_tmr_if tmrBus ();

    uhpd_timer #(
        .WAIT_TICKS (WAIT_TICKS)
    ) uTimer (
        .clk  (clk),
        .srst (srst),
        .tmr  (tmrBus.tmr)
    );

    // Line level is a transceiver pin, so it is synchronised first
    uhpd_sync #(
        .W (2)
    ) uLineSync (
        .clk  (clk),
        .srst (srst),
        .d    (busLineLevel),
        .q    (lineSync)
    );

    // Bus slave: every access waits exactly one cycle
    wire busReq = avs_read | avs_write;
    wire wrTake = avs_write & busAck_r;
    wire rdLoad = avs_read & ~busAck_r;
    assign avs_waitrequest = busReq & ~busAck_r;

    wire selCtrl = avs_address == REG_CTRL;
    wire selXcvr = avs_address == REG_XCVR;
    wire selStat = avs_address == REG_STAT;
    wire selClr  = avs_address == REG_CLR;
    wire selIen  = avs_address == REG_IEN;

    wire wrCtrl = wrTake & selCtrl;
    wire wrXcvr = wrTake & selXcvr;
    wire wrClr  = wrTake & selClr;
    wire wrIen  = wrTake & selIen;

    wire [CMD_W-1:0] cmdVal = avs_writedata[CTRL_CMD_LSB +: CMD_W];
    wire             isIdle = state_r == ST_IDLE;

    // Commands are only taken while no sequence runs
    wire cmdDis = wrCtrl && isIdle && cmdVal == CMD_GO_DISABLED;
    wire cmdRst = wrCtrl && isIdle && cmdVal == CMD_GO_RESET;
    wire cmdOp  = wrCtrl && isIdle && cmdVal == CMD_GO_OPERATIONAL;
    wire cmdWc  = wrCtrl && isIdle && cmdVal == CMD_GO_WAIT_CONNECT;

    wire evtConn = connectDetected && host_state_monitor_r == HST_WAIT_CONNECT;
    wire evtChrp = erraticChirp && host_state_monitor_r == HST_RESET;
    wire evtPerr = portError && host_state_monitor_r == HST_OPERATIONAL;
    wire evtDis  = isIdle && !wrCtrl && (evtConn || evtChrp || evtPerr);

    wire startDis = cmdDis || evtDis;
    wire inOper   = host_state_monitor_r == HST_OPERATIONAL;
    wire rstDefer = cmdRst && inOper;
    wire rstNow   = cmdRst && !inOper;
    wire rstLate  = state_r == ST_RST_TXN && !txnBusy;
    wire rstEnter = rstNow || rstLate;
    wire pdGo     = state_r == ST_DIS_TXN && !txnBusy;
    wire pdDone   = state_r == ST_DIS_PD && tmrBus.done;

    assign tmrBus.start = pdGo;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (startDis) begin
                    state_nxt = ST_DIS_TXN;
                end else if (rstDefer) begin
                    state_nxt = ST_RST_TXN;
                end
            end
            ST_DIS_TXN: begin
                if (pdGo) begin
                    state_nxt = ST_DIS_PD;
                end
            end
            ST_DIS_PD: begin
                if (pdDone) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RST_TXN: begin
                if (rstLate) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            host_state_monitor_r <= HST_IDLE;
        end else if (startDis) begin
            host_state_monitor_r <= HST_DISABLED;
        end else if (rstEnter) begin
            host_state_monitor_r <= HST_RESET;
        end else if (cmdOp) begin
            host_state_monitor_r <= HST_OPERATIONAL;
        end else if (cmdWc) begin
            host_state_monitor_r <= HST_WAIT_CONNECT;
        end
    end

    // Detection drops at disable start, at least one cycle ahead of power-down; go-wait-connect drops it with the mode change
    always_ff @(posedge clk) begin
        if (srst) begin
            discEn_r <= 1'b0;
        end else if (startDis || cmdWc) begin
            discEn_r <= 1'b0;
        end else if (pdDone || cmdOp) begin
            discEn_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            transceiver_operation_mode_r <= OPM_PWRDN;
        end else if (pdGo || cmdWc) begin
            transceiver_operation_mode_r <= OPM_PWRDN;
        end else if (rstEnter || cmdOp) begin
            transceiver_operation_mode_r <= OPM_NORMAL;
        end
    end

    // Speed settings move only on firmware writes or reset entry
    always_ff @(posedge clk) begin
        if (srst) begin
            speedSel_r  <= SEL_FS;
            termSel_r   <= TERM_FS;
            port_speed_setting_r <= SEL_FS;
        end else if (rstEnter) begin
            speedSel_r <= SEL_HS;
            termSel_r  <= TERM_HS;
        end else if (wrXcvr && isIdle) begin
            speedSel_r  <= avs_writedata[XCVR_XSEL_LSB +: 2];
            termSel_r   <= avs_writedata[XCVR_TERM_BIT];
            port_speed_setting_r <= avs_writedata[XCVR_SPD_LSB +: 2];
        end
    end

    // Sticky events; a set in the clear cycle survives
    always_comb begin
        statSet                = '0;
        statSet[STAT_DONE_BIT] = pdDone;
        statSet[STAT_RST_BIT]  = rstEnter;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            stat_r <= '0;
            ien_r  <= '0;
        end else begin
            stat_r <= (stat_r & ~(wrClr ? avs_writedata[STAT_W-1:0] : '0)) | statSet;
            if (wrIen) begin
                ien_r <= avs_writedata[STAT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_r        <= 1'b0;
            resetStart_r <= 1'b0;
            busAck_r     <= 1'b0;
        end else begin
            irq_r        <= |(stat_r & ien_r);
            resetStart_r <= rstEnter;
            busAck_r     <= busReq & ~busAck_r;
        end
    end

    // Read views
    always_comb begin
        ctrlView                             = '0;
        ctrlView[CTRL_CMD_LSB +: CMD_W]      = host_state_monitor_r;
        ctrlView[CTRL_BUSY_BIT]              = !isIdle;
        ctrlView[CTRL_DISC_BIT]              = discEn_r;
        xcvrView                             = '0;
        xcvrView[XCVR_OPM_LSB +: 2]          = transceiver_operation_mode_r;
        xcvrView[XCVR_XSEL_LSB +: 2]         = speedSel_r;
        xcvrView[XCVR_TERM_BIT]              = termSel_r;
        xcvrView[XCVR_SPD_LSB +: 2]          = port_speed_setting_r;
        xcvrView[XCVR_LINE_LSB +: 2]         = lineSync;
    end

    wire [DATA_W-1:0] rdMux = selCtrl ? ctrlView :
                              selXcvr ? xcvrView :
                              selStat ? {{(DATA_W-STAT_W){1'b0}}, stat_r} :
                              selIen  ? {{(DATA_W-STAT_W){1'b0}}, ien_r} :
                              '0;

    always_ff @(posedge clk) begin
        if (srst) begin
            readData_r <= '0;
        end else if (rdLoad) begin
            readData_r <= rdMux;
        end
    end

    assign avs_readdata             = readData_r;
    assign transceiverOperationMode = transceiver_operation_mode_r;
    assign transceiverSpeedSelect   = speedSel_r;
    assign terminationSelect        = termSel_r;
    assign portSpeedSetting         = port_speed_setting_r;
    assign disconnectDetectEn       = discEn_r;
    assign hostStateMonitor         = host_state_monitor_r;
    assign resetStart               = resetStart_r;
    assign irq                      = irq_r;

    // Checks
    int unsigned pdCyc;
    always_ff @(posedge clk) begin
        if (srst || pdGo) begin
            pdCyc <= 0;
        end else if (state_r == ST_DIS_PD) begin
            pdCyc <= pdCyc + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    dis_state_a: assert property (cmdDis |=> hostStateMonitor == HST_DISABLED)
        else $error("host state not DISABLED after go-disabled");

    disc_off_a: assert property (startDis |=> !disconnectDetectEn [*2])
        else $error("disconnect detection not dropped at command");

    pd_order_a: assert property ($changed(transceiverOperationMode)
        && transceiverOperationMode == OPM_PWRDN && hostStateMonitor == HST_DISABLED
        |-> !$past(disconnectDetectEn) && !$past(txnBusy))
        else $error("power-down before transaction end or with detection on");

    pd_wait_a: assert property (state_r == ST_DIS_TXN && !txnBusy
        |=> transceiverOperationMode == OPM_PWRDN)
        else $error("power-down missed after transaction end");

    keep_sel_a: assert property (!isIdle && state_r != ST_RST_TXN
        |=> $stable(transceiverSpeedSelect) && $stable(terminationSelect)
            && $stable(portSpeedSetting))
        else $error("speed settings moved during disable");

    no_early_a: assert property (pdDone
        |-> pdCyc == WAIT_TICKS * TICK_CYC - 1)
        else $error("detection re-enable at wrong time");

    flag_pair_a: assert property ($rose(disconnectDetectEn) && hostStateMonitor == HST_DISABLED
        |-> stat_r[STAT_DONE_BIT] && $past(state_r) == ST_DIS_PD)
        else $error("completion flag not raised with re-enable");

    rst_hold_a: assert property (state_r == ST_RST_TXN && txnBusy
        |=> hostStateMonitor == HST_OPERATIONAL)
        else $error("reset began during transaction");

    rst_go_a: assert property (rstEnter
        |=> hostStateMonitor == HST_RESET && transceiverOperationMode == OPM_NORMAL
            && resetStart ##1 !resetStart)
        else $error("reset entry steps missing");

    auto_dis_a: assert property (evtDis
        |=> hostStateMonitor == HST_DISABLED ##1 state_r inside {ST_DIS_TXN, ST_DIS_PD})
        else $error("event did not start disable");

    tmr_run_a: assert property (state_r == ST_DIS_PD |-> tmrBus.busy)
        else $error("power-down timer idle during wait");

    dis_done_c: cover property (pdDone ##1 disconnectDetectEn);
    rst_defer_c: cover property (rstDefer ##1 txnBusy [*2] ##1 rstLate);
    auto_dis_c: cover property (evtPerr && isIdle ##1 state_r == ST_DIS_TXN);
endmodule

// File: bench/uhpd_periph_model.sv
// Purpose: Behavioural full/low speed peripheral on the port
// Assumes: Bench requests each transaction with a length in cycles
// Notes:   Suspend span is scaled down to match the short timer
module uhpd_periph_model #(
    parameter int SUSP_CYC = 100
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       txnGo,
    input  wire logic [7:0] txnLen,
    input  wire logic [1:0] transceiver_operation_mode,
    output logic            txnBusy,
    output logic [1:0]      lineLevel,
    output logic            suspended
);
    timeunit 1ns;
    timeprecision 1ps;
    import uhpd_pkg::*;

    logic [7:0] busyCnt_r;
    int         quiet_r;
    logic       flip_r;

    // Toggling pattern, so a stale level never passes for traffic
    assign txnBusy   = busyCnt_r != 8'h00;
    assign lineLevel = txnBusy ? {flip_r, ~flip_r} : 2'h1;
    assign suspended = quiet_r >= SUSP_CYC;

    always_ff @(posedge clk) begin
        if (srst) begin
            busyCnt_r <= 8'h00;
            quiet_r   <= 0;
            flip_r    <= 1'b0;
        end else begin
            flip_r    <= ~flip_r;
            busyCnt_r <= txnGo ? txnLen : busyCnt_r - {7'h00, txnBusy};
            // Quiet span only runs once the host is idle and powered down
            quiet_r   <= (transceiver_operation_mode == OPM_PWRDN && !txnBusy) ? quiet_r + {31'h0, !suspended} : 0;
        end
    end
endmodule

// File: bench/uhpd_top_bench.sv
// Purpose: Self-checking bench for the host port sequencer
// Assumes: Short timer, WAIT_TICKS of 3
// Notes:   Pin outputs are sampled on the falling edge, once settled; bus read data at the rising edge
module uhpd_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import uhpd_pkg::*;

    localparam int unsigned WT  = 3;
    localparam int          WCY = WT * TICK_CYC;

    logic              clk           = 1'b0;
    logic              srst          = 1'b1;
    logic [ADDR_W-1:0] avs_address   = 5'h00;
    logic              avs_read      = 1'b0;
    logic              avs_write     = 1'b0;
    logic [DATA_W-1:0] avs_writedata = 32'h0;
    logic [2:0]        evtBus        = 3'h0;
    logic              txnGo         = 1'b0;
    logic [7:0]        txnLen        = 8'h00;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              txnBusy;
    logic              suspended;
    logic [1:0]        lineLevel;
    logic [1:0]        transceiver_operation_mode;
    logic [1:0]        speedSel;
    logic              term;
    logic [1:0]        portSpd;
    logic              discEn;
    logic [2:0]        host_state_monitor;
    logic              resetStart;
    logic              irq;
    int                fails    = 0;
    int                compares = 0;

    always #10 clk = ~clk;

    uhpd_top #(.WAIT_TICKS(WT)) uhpd_top_i (
        .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .txnBusy(txnBusy),
        .connectDetected(evtBus[2]), .erraticChirp(evtBus[1]), .portError(evtBus[0]),
        .busLineLevel(lineLevel), .transceiverOperationMode(transceiver_operation_mode),
        .transceiverSpeedSelect(speedSel), .terminationSelect(term),
        .portSpeedSetting(portSpd), .disconnectDetectEn(discEn),
        .hostStateMonitor(host_state_monitor), .resetStart(resetStart), .irq(irq)
    );

    uhpd_periph_model #(.SUSP_CYC(100)) uhpd_periph_model_i (
        .clk(clk), .srst(srst), .txnGo(txnGo), .txnLen(txnLen), .transceiver_operation_mode(transceiver_operation_mode),
        .txnBusy(txnBusy), .lineLevel(lineLevel), .suspended(suspended)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (n >= 50) fails++;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFFFFFF);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask

    task automatic pulse_txn(input logic [7:0] len);
        @(posedge clk);
        txnGo  <= 1'b1;
        txnLen <= len;
        @(posedge clk);
        txnGo  <= 1'b0;
    endtask

    task automatic wait_done(output int n);
        n = 0;
        while (discEn !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic t_reset;
        @(negedge clk);
        chk({transceiver_operation_mode, speedSel, term, portSpd, discEn, host_state_monitor, resetStart, irq},
            {OPM_PWRDN, SEL_FS, TERM_FS, SEL_FS, 1'b0, HST_IDLE, 2'h0});
        rd(REG_CTRL, 32'h0);
        rd(REG_XCVR, 32'h136);
        wr(REG_STAT, 32'h3);
        rd(REG_STAT, 32'h0);
        rd(REG_IEN, 32'h0);
        rd(5'h14, 32'h0);
    endtask

    task automatic t_disable;
        int n;
        wr(REG_IEN, 32'h1);
        wr(REG_XCVR, 32'h58);
        wr(REG_CTRL, {29'h0, CMD_GO_OPERATIONAL});
        @(negedge clk);
        chk({host_state_monitor, transceiver_operation_mode, discEn}, {HST_OPERATIONAL, OPM_NORMAL, 1'b1});
        pulse_txn(8'h28);
        wr(REG_CTRL, {29'h0, CMD_GO_DISABLED});
        @(negedge clk);
        chk({host_state_monitor, discEn, transceiver_operation_mode}, {HST_DISABLED, 1'b0, OPM_NORMAL});
        // Commands and settings are refused while the sequence runs
        wr(REG_CTRL, {29'h0, CMD_GO_RESET});
        wr(REG_XCVR, 32'h0);
        @(negedge clk);
        chk({host_state_monitor, speedSel, transceiver_operation_mode, txnBusy}, {HST_DISABLED, SEL_LS, OPM_NORMAL, 1'b1});
        n = 0;
        while (transceiver_operation_mode !== OPM_PWRDN && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(txnBusy, 1'b0);
        wait_done(n);
        chk(n, WCY);
        chk({irq, suspended}, 2'h1);
        @(negedge clk);
        chk(irq, 1'b1);
        chk({speedSel, term, portSpd}, {SEL_LS, TERM_FS, SEL_LS});
        rd(REG_STAT, 32'h1);
        wr(REG_CLR, 32'h1);
        rd(REG_STAT, 32'h0);
        @(negedge clk);
        chk(irq, 1'b0);
    endtask

    task automatic t_reset_cmd;
        int n;
        wr(REG_CTRL, {29'h0, CMD_GO_OPERATIONAL});
        pulse_txn(8'h14);
        wr(REG_CTRL, {29'h0, CMD_GO_RESET});
        rd(REG_CTRL, 32'h104, 32'h107);
        n = 0;
        while (host_state_monitor !== HST_RESET && n < 100) begin
            @(negedge clk);
            n++;
        end
        // Start pulse is registered alongside the state, so both show together
        chk({txnBusy, speedSel, term, transceiver_operation_mode, resetStart},
            {1'b0, SEL_HS, TERM_HS, OPM_NORMAL, 1'b1});
        @(negedge clk);
        chk(resetStart, 1'b0);
        rd(REG_STAT, 32'h2);
        wr(REG_CLR, 32'h3);
    endtask

    task automatic t_events;
        logic [2:0] cmd [3];
        int         n;
        cmd = '{CMD_GO_WAIT_CONNECT, CMD_GO_RESET, CMD_GO_OPERATIONAL};
        wr(REG_IEN, 32'h0);
        for (int k = 0; k < 3; k++) begin
            wr(REG_CTRL, {29'h0, cmd[k]});
            @(posedge clk);
            evtBus <= 3'h4 >> k;
            @(posedge clk);
            evtBus <= 3'h0;
            @(negedge clk);
            chk({host_state_monitor, discEn}, {HST_DISABLED, 1'b0});
            wait_done(n);
            chk(n, WCY + 1);
            @(negedge clk);
            chk(irq, 1'b0);
        end
        rd(REG_STAT, 32'h3);
        wr(REG_CLR, 32'h3);
        rd(REG_STAT, 32'h0);
    endtask

    task automatic final_report;
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_disable;
        t_reset_cmd;
        t_events;
        final_report;
    end

    // Whole run needs about 800 cycles
    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        final_report;
    end
endmodule
